// file: pkg/dpe_pkg.sv
// Shared constants and types for the dual-port two-wire EEPROM block
package dpe_pkg;
   // ==================================================================
   // Control byte and array geometry
   localparam logic [3:0] CTRL_CODE = 4'ha;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam int MON_AW = 7;
   localparam int HOST_AW = 9;
   localparam int MON_PW = 3;
   localparam int HOST_PW = 4;
   localparam logic [7:0] ERASED = 8'hff;
   localparam int BS_LOW_POS = 1;
   localparam int RW_POS = 0;
   // ==================================================================
   // Timing
   localparam int CORE_PERIOD_NS = 25;
   localparam int SPIKE_NS = 50;
   localparam int FILTER_CYCLES = (SPIKE_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
   localparam int FILT_W = 2;
   localparam int WRITE_NS = 10000000;
   localparam int WRITE_CYCLES = WRITE_NS / CORE_PERIOD_NS;
   // ==================================================================
   // Input slots of the sampling and filtering bank
   localparam int IN_MON_SCL = 0;
   localparam int IN_MON_SDA = 1;
   localparam int IN_HOST_SCL = 2;
   localparam int IN_HOST_SDA = 3;
   localparam int IN_VCLK = 4;
   localparam int IN_HWP = 5;
   localparam int IN_LOW = 6;
   localparam int IN_COUNT = 7;
   // ==================================================================
   // Slave protocol states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_CTRL,
      ST_ADDR,
      ST_WDATA,
      ST_ACK,
      ST_RDATA,
      ST_RACK
   } dpe_state_type;
endpackage

// file: rtl/dpe_top.sv
// Dual-port two-wire EEPROM: port slaves, input filters and transmit-only stream
// Contract
// - Monitor port writes only while video clock/protect pin is high.
// - Protect pin held low makes monitor port read-only; no stream possible.
// - Host protect pin high inhibits all host writes; reads still work.
// - Host protect pin low allows host reads and writes everywhere.
// - A read starts like a write, with direction bit set to one.
// - Each port does current, random, sequential reads, fully independently.
// - Address counter holds last accessed address plus one.
// - Read control byte is acknowledged, then a byte from current address.
// - Master ends read with no-acknowledge and stop; port stops sending.
// - Repeated start after word address aborts write but keeps pointer.
// - Master acknowledge during read makes port send the next byte.
// - Pointer increments after every operation so whole array reads.
// - Low-supply indication blocks all erase and write activity.
// - All four clock and data inputs are filtered against spikes.
// - Monitor data pin is two-way in bus mode, output only in stream mode.
// - Data pins are open-drain: pulled low or released only.
// - Data changes while clock low; changes with clock high are start/stop.
// - Monitor clock high keeps stream mode; its falling edge leaves it.
// - Stream bits go out on rising edges of the video clock.
// - Only control bytes with type code 1010 are answered.
// - Host block-select low bit is address MSB; monitor ignores block bits.
// - No acknowledge while an internal write cycle runs.
`timescale 1ns/1ps

// ======================================================================
// One two-wire slave port with its own array
module dpe_port #(
   parameter int AW = 7,
   parameter int PW = 3,
   parameter bit HOST = 1'b0,
   parameter int WRITE_CYCLES = 400000
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic enable,
   input wire logic scl,
   input wire logic sda,
   input wire logic write_ok,
   input wire logic [AW-1:0] stream_addr,
   output logic sda_oe,
   output logic [7:0] stream_data
);
   localparam int BW = $clog2(WRITE_CYCLES + 1);
   localparam logic [AW-1:0] HIGH_MASK = AW'(((2 ** AW) - 1) & ~255);
   localparam logic [AW-1:0] PAGE_MASK = AW'((2 ** PW) - 1);

   dpe_pkg::dpe_state_type state;
   dpe_pkg::dpe_state_type ack_next;
   logic scl_d, sda_d, macked, wrote;
   logic [3:0] bitcnt;
   logic [7:0] shreg;
   logic [AW-1:0] addr;
   logic [BW-1:0] busy_cnt;
   logic [7:0] mem [2 ** AW];
   logic scl_rise, scl_fall, start_c, stop_c, byte_done, busy, start_tx, mem_we, code_ok;

   assign scl_rise = scl & ~scl_d;
   assign scl_fall = ~scl & scl_d;
   assign start_c = scl & scl_d & sda_d & ~sda;
   assign stop_c = scl & scl_d & ~sda_d & sda;
   assign byte_done = scl_fall && (bitcnt == dpe_pkg::BYTE_BITS);
   assign busy = (busy_cnt != '0);
   assign code_ok = (shreg[7:4] == dpe_pkg::CTRL_CODE) && !busy;
   assign start_tx = scl_fall && ((state == dpe_pkg::ST_ACK && ack_next == dpe_pkg::ST_RDATA)
                     || (state == dpe_pkg::ST_RACK && macked));
   assign mem_we = byte_done && state == dpe_pkg::ST_WDATA && write_ok;
   assign stream_data = mem[stream_addr];

   // ======================================================================
   // Edge history of the filtered bus lines
   always_ff @(posedge core_clk) begin
      if (reset) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl;
         sda_d <= sda;
      end
   end

   // ======================================================================
   // Protocol sequencer; sda_oe high pulls the line low
   always_ff @(posedge core_clk) begin
      if (reset || !enable) begin
         state <= dpe_pkg::ST_IDLE;
         ack_next <= dpe_pkg::ST_IDLE;
         bitcnt <= 4'h0;
         shreg <= 8'h00;
         macked <= 1'b0;
         sda_oe <= 1'b0;
      end else if (start_c) begin
         state <= dpe_pkg::ST_CTRL;
         bitcnt <= 4'h0;
         sda_oe <= 1'b0;
      end else if (stop_c) begin
         state <= dpe_pkg::ST_IDLE;
         sda_oe <= 1'b0;
      end else if (start_tx) begin
         state <= dpe_pkg::ST_RDATA;
         shreg <= mem[addr];
         sda_oe <= ~mem[addr][7];
         bitcnt <= 4'h1;
      end else begin
         unique case (state)
            dpe_pkg::ST_IDLE: begin
               bitcnt <= 4'h0;
            end
            dpe_pkg::ST_CTRL, dpe_pkg::ST_ADDR, dpe_pkg::ST_WDATA: begin
               if (scl_rise) begin
                  shreg <= {shreg[6:0], sda};
                  bitcnt <= bitcnt + 4'h1;
               end else if (byte_done) begin
                  bitcnt <= 4'h0;
                  if (state != dpe_pkg::ST_CTRL) begin
                     sda_oe <= 1'b1;
                     ack_next <= dpe_pkg::ST_WDATA;
                     state <= dpe_pkg::ST_ACK;
                  end else if (code_ok) begin
                     sda_oe <= 1'b1;
                     ack_next <= shreg[dpe_pkg::RW_POS] ? dpe_pkg::ST_RDATA
                                 : dpe_pkg::ST_ADDR;
                     state <= dpe_pkg::ST_ACK;
                  end else begin
                     state <= dpe_pkg::ST_IDLE;
                  end
               end
            end
            dpe_pkg::ST_ACK: begin
               if (scl_fall) begin
                  sda_oe <= 1'b0;
                  bitcnt <= 4'h0;
                  state <= ack_next;
               end
            end
            dpe_pkg::ST_RDATA: begin
               if (scl_fall) begin
                  if (bitcnt == dpe_pkg::BYTE_BITS) begin
                     sda_oe <= 1'b0; // Release so the master can answer
                     state <= dpe_pkg::ST_RACK;
                  end else begin
                     sda_oe <= ~shreg[6];
                     shreg <= {shreg[6:0], 1'b0};
                     bitcnt <= bitcnt + 4'h1;
                  end
               end
            end
            dpe_pkg::ST_RACK: begin
               if (scl_rise) begin
                  macked <= ~sda;
               end else if (scl_fall) begin
                  state <= dpe_pkg::ST_IDLE;
                  sda_oe <= 1'b0;
               end
            end
         endcase
      end
   end

   // ======================================================================
   // Address pointer
   always_ff @(posedge core_clk) begin
      if (reset) begin
         addr <= '0;
      end else if (enable) begin
         if (byte_done && state == dpe_pkg::ST_CTRL && code_ok) begin
            if (HOST) begin
               addr <= {shreg[dpe_pkg::BS_LOW_POS], addr[AW-2:0]};
            end
         end else if (byte_done && state == dpe_pkg::ST_ADDR) begin
            addr <= (addr & HIGH_MASK) | AW'(shreg);
         end else if (byte_done && state == dpe_pkg::ST_WDATA) begin
            // Page writes wrap inside the page, as the array page buffer does
            addr <= (addr & ~PAGE_MASK) | ((addr + 1'b1) & PAGE_MASK);
         end else if (start_tx) begin
            addr <= addr + 1'b1;
         end
      end
   end

   // ======================================================================
   // Array storage; bytes land as they arrive and the timed cycle follows the stop
   always_ff @(posedge core_clk) begin
      if (reset) begin
         for (int i = 0; i < 2 ** AW; i++) begin
            mem[i] <= dpe_pkg::ERASED;
         end
      end else if (mem_we) begin
         mem[addr] <= shreg;
      end
   end

   // ======================================================================
   // Internal write cycle timer
   always_ff @(posedge core_clk) begin
      if (reset) begin
         wrote <= 1'b0;
         busy_cnt <= '0;
      end else begin
         if (start_c || stop_c) begin
            wrote <= 1'b0;
         end else if (mem_we) begin
            wrote <= 1'b1;
         end
         if (stop_c && wrote && enable) begin
            busy_cnt <= BW'(WRITE_CYCLES);
         end else if (busy) begin
            busy_cnt <= busy_cnt - 1'b1;
         end
      end
   end

   // ======================================================================
   // Checks
   property p_write_gated;
      @(posedge core_clk) disable iff (reset)
      mem_we |=> mem[$past(addr)] == $past(shreg) && $past(write_ok);
   endproperty
   a_write_gated: assert property (p_write_gated)
      else $error("array written without write permission");

   property p_refuse_write;
      @(posedge core_clk) disable iff (reset)
      (byte_done && state == dpe_pkg::ST_WDATA && !write_ok) |=> mem[$past(addr)] == $past(mem[addr]);
   endproperty
   a_refuse_write: assert property (p_refuse_write)
      else $error("protected location changed");

   property p_busy_nack;
      @(posedge core_clk) disable iff (reset || !enable)
      (busy && byte_done && state == dpe_pkg::ST_CTRL) |=> !sda_oe && state == dpe_pkg::ST_IDLE;
   endproperty
   a_busy_nack: assert property (p_busy_nack)
      else $error("acknowledge given during write cycle");

   property p_code_check;
      @(posedge core_clk) disable iff (reset || !enable)
      (byte_done && state == dpe_pkg::ST_CTRL && shreg[7:4] != dpe_pkg::CTRL_CODE)
      |=> state == dpe_pkg::ST_IDLE ##1 !sda_oe;
   endproperty
   a_code_check: assert property (p_code_check)
      else $error("foreign control code answered");

   property p_read_ack;
      @(posedge core_clk) disable iff (reset || !enable || busy)
      (byte_done && state == dpe_pkg::ST_CTRL && shreg[7:4] == dpe_pkg::CTRL_CODE && shreg[0])
      |=> sda_oe && state == dpe_pkg::ST_ACK && ack_next == dpe_pkg::ST_RDATA;
   endproperty
   a_read_ack: assert property (p_read_ack)
      else $error("read control byte not acknowledged");

   property p_ptr_step;
      @(posedge core_clk) disable iff (reset || !enable)
      start_tx |=> addr == $past(addr) + 1'b1 && shreg == $past(mem[addr]);
   endproperty
   a_ptr_step: assert property (p_ptr_step)
      else $error("pointer did not advance by one after read byte");

   property p_read_end;
      @(posedge core_clk) disable iff (reset || !enable)
      (state == dpe_pkg::ST_RACK && scl_fall && !macked && !start_c && !stop_c)
      |=> state == dpe_pkg::ST_IDLE && !sda_oe;
   endproperty
   a_read_end: assert property (p_read_end)
      else $error("port kept sending after no-acknowledge");

   property p_restart_keeps;
      @(posedge core_clk) disable iff (reset || !enable)
      (start_c && (state == dpe_pkg::ST_ACK || state == dpe_pkg::ST_WDATA))
      |=> state == dpe_pkg::ST_CTRL && addr == $past(addr);
   endproperty
   a_restart_keeps: assert property (p_restart_keeps)
      else $error("repeated start lost the address pointer");
endmodule // dpe_port

// ======================================================================
// Top level: filters, mode control, both ports and the stream link
module dpe_top #(
   parameter int WRITE_CYCLES = dpe_pkg::WRITE_CYCLES
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic video_clock_protect,
   input wire logic monitor_serial_clock,
   input wire logic monitor_serial_data_in,
   output logic monitor_serial_data_out,
   output logic monitor_serial_data_oe,
   input wire logic host_serial_clock,
   input wire logic host_serial_data_in,
   output logic host_serial_data_out,
   output logic host_serial_data_oe,
   input wire logic host_protect_pin,
   input wire logic supply_low,
   output logic monitor_transmit_only
);
   logic [dpe_pkg::IN_COUNT-1:0] raw;
   logic filt [dpe_pkg::IN_COUNT];
   logic sync_m [dpe_pkg::IN_COUNT];
   logic sync_c [dpe_pkg::IN_COUNT];
   logic mon_scl_prev, mon_oe, host_oe, mon_ok, host_ok;
   logic req_m, req_c, stage_ack, bit_m, bit_c;
   logic [7:0] staged, stream_data;
   logic [dpe_pkg::MON_AW-1:0] stream_addr, stream_next;
   logic link_rst_m, link_rst, tx_m, tx_l, ack_m, ack_l, link_req, stream_bit;
   logic [2:0] link_cnt;
   logic [7:0] link_sh;

   assign raw = {supply_low, host_protect_pin, video_clock_protect, host_serial_data_in,
                 host_serial_clock, monitor_serial_data_in, monitor_serial_clock};

   // ======================================================================
   // Two-flop sampling then spike filter on every pin input
   for (genvar i = 0; i < dpe_pkg::IN_COUNT; i++) begin : g_in
      logic [dpe_pkg::FILT_W-1:0] cnt;
      always_ff @(posedge core_clk) begin
         if (reset) begin
            sync_m[i] <= 1'b1;
            sync_c[i] <= 1'b1;
         end else begin
            sync_m[i] <= raw[i];
            sync_c[i] <= sync_m[i];
         end
      end
      always_ff @(posedge core_clk) begin
         if (reset) begin
            filt[i] <= 1'b1;
            cnt <= '0;
         end else if (sync_c[i] == filt[i]) begin
            cnt <= '0;
         end else if (cnt == dpe_pkg::FILT_W'(dpe_pkg::FILTER_CYCLES - 1)) begin
            filt[i] <= sync_c[i];
            cnt <= '0;
         end else begin
            cnt <= cnt + 1'b1;
         end
      end
      property p_filter;
         @(posedge core_clk) disable iff (reset)
         $changed(filt[i]) |-> $past(sync_c[i], 1) == filt[i] && $past(sync_c[i], 2) == filt[i];
      endproperty
      a_filter: assert property (p_filter)
         else $error("filtered input followed a short spike");
   end

   // The supply-low input feeds both ports, so permissions are combined here once
   assign mon_ok = filt[dpe_pkg::IN_VCLK] & ~filt[dpe_pkg::IN_LOW];
   assign host_ok = ~filt[dpe_pkg::IN_HWP] & ~filt[dpe_pkg::IN_LOW];

   // ======================================================================
   // Mode: stream after reset, bus mode after a clean falling monitor clock
   always_ff @(posedge core_clk) begin
      if (reset) begin
         mon_scl_prev <= 1'b1;
         monitor_transmit_only <= 1'b1;
      end else begin
         mon_scl_prev <= filt[dpe_pkg::IN_MON_SCL];
         if (mon_scl_prev && !filt[dpe_pkg::IN_MON_SCL]) begin
            monitor_transmit_only <= 1'b0;
         end
      end
   end

   dpe_port #(
      .AW(dpe_pkg::MON_AW),
      .PW(dpe_pkg::MON_PW),
      .HOST(1'b0),
      .WRITE_CYCLES(WRITE_CYCLES)
   ) u_monitor (
      .core_clk(core_clk),
      .reset(reset),
      .enable(~monitor_transmit_only),
      .scl(filt[dpe_pkg::IN_MON_SCL]),
      .sda(filt[dpe_pkg::IN_MON_SDA]),
      .write_ok(mon_ok),
      .stream_addr(stream_next),
      .sda_oe(mon_oe),
      .stream_data(stream_data)
   );

   dpe_port #(
      .AW(dpe_pkg::HOST_AW),
      .PW(dpe_pkg::HOST_PW),
      .HOST(1'b1),
      .WRITE_CYCLES(WRITE_CYCLES)
   ) u_host (
      .core_clk(core_clk),
      .reset(reset),
      .enable(1'b1),
      .scl(filt[dpe_pkg::IN_HOST_SCL]),
      .sda(filt[dpe_pkg::IN_HOST_SDA]),
      .write_ok(host_ok),
      .stream_addr('0),
      .sda_oe(host_oe),
      .stream_data()
   );

   // ======================================================================
   // Core side of the stream: stage the next byte on each link request
   assign stream_next = dpe_pkg::MON_AW'(stream_addr + 1'b1);

   always_ff @(posedge core_clk) begin
      if (reset) begin
         req_m <= 1'b0;
         req_c <= 1'b0;
         bit_m <= 1'b1;
         bit_c <= 1'b1;
      end else begin
         req_m <= link_req;
         req_c <= req_m;
         bit_m <= stream_bit;
         bit_c <= bit_m;
      end
   end

   // Staged byte only changes between a link request and its acknowledge, so it is stable when taken
   always_ff @(posedge core_clk) begin
      if (reset) begin
         stream_addr <= '0;
         staged <= dpe_pkg::ERASED;
         stage_ack <= 1'b0;
      end else if (req_c != stage_ack) begin
         stream_addr <= stream_next;
         staged <= stream_data;
         stage_ack <= req_c;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         monitor_serial_data_oe <= 1'b0;
         host_serial_data_oe <= 1'b0;
         monitor_serial_data_out <= 1'b0;
         host_serial_data_out <= 1'b0;
      end else begin
         monitor_serial_data_oe <= monitor_transmit_only ? ~bit_c : mon_oe;
         host_serial_data_oe <= host_oe;
         monitor_serial_data_out <= 1'b0;
         host_serial_data_out <= 1'b0;
      end
   end

   // ======================================================================
   // Link side, clocked by the video clock; idles high in reset and bus mode, holds its last bit while awaiting the acknowledge
   always_ff @(posedge video_clock_protect) begin
      link_rst_m <= reset;
      link_rst <= link_rst_m;
      tx_m <= monitor_transmit_only;
      tx_l <= tx_m;
      ack_m <= stage_ack;
      ack_l <= ack_m;
   end

   always_ff @(posedge video_clock_protect) begin
      if (link_rst) begin
         stream_bit <= 1'b1;
         link_cnt <= 3'h0;
         link_req <= 1'b0;
         link_sh <= 8'hff;
      end else if (!tx_l) begin
         stream_bit <= 1'b1;
         link_cnt <= 3'h0;
      end else if (link_cnt != 3'h0) begin
         stream_bit <= link_sh[7];
         link_sh <= {link_sh[6:0], 1'b1};
         link_cnt <= link_cnt - 3'h1;
      end else if (ack_l == link_req) begin
         stream_bit <= staged[7];
         link_sh <= {staged[6:0], 1'b1};
         link_cnt <= 3'h7;
         link_req <= ~link_req;
      end
   end

   // ======================================================================
   // Checks
   property p_open_drain;
      @(posedge core_clk) disable iff (reset)
      !monitor_serial_data_out && !host_serial_data_out;
   endproperty
   a_open_drain: assert property (p_open_drain)
      else $error("data pin driven high");

   property p_mode_sticky;
      @(posedge core_clk) disable iff (reset)
      !monitor_transmit_only |=> !monitor_transmit_only;
   endproperty
   a_mode_sticky: assert property (p_mode_sticky)
      else $error("returned to stream mode without reset");

   property p_stream_advance;
      @(posedge core_clk) disable iff (reset)
      (req_c != stage_ack) |=> stream_addr == $past(stream_addr) + 1'b1 && stage_ack == req_c;
   endproperty
   a_stream_advance: assert property (p_stream_advance)
      else $error("stream address did not step");

   property p_stream_shift;
      @(posedge video_clock_protect) disable iff (link_rst)
      (tx_l && link_cnt != 3'h0) |=> stream_bit == $past(link_sh[7]);
   endproperty
   a_stream_shift: assert property (p_stream_shift)
      else $error("stream bit not shifted on video clock edge");
endmodule // dpe_top

// file: verif/dpe_master.sv
// Two-wire bus master model for one port of the EEPROM
`timescale 1ns/1ps
module dpe_master (
   input wire logic clk,
   input wire logic sda,
   output logic scl,
   output logic sda_low,
   output logic got,
   output logic [8:0] res
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
      got = 1'b0;
      res = 9'h000;
   end
   // ==================================================================
   // Bus phases
   // Phases of 12 core cycles leave room for the input filter delay
   task automatic half();
      repeat (12) @(posedge clk);
      #2;
   endtask
   task automatic st();
      sda_low = 1'b0;
      half();
      scl = 1'b1;
      half();
      sda_low = 1'b1;
      half();
      scl = 1'b0;
   endtask
   task automatic sp();
      sda_low = 1'b1;
      half();
      scl = 1'b1;
      half();
      sda_low = 1'b0;
      half();
   endtask
   // Eight bits then the ninth; bit value 1 releases the line
   task automatic xfer(input logic [7:0] b, input logic k);
      logic [8:0] w;
      w = {b, k};
      for (int i = 8; i >= 0; i--) begin
         sda_low = ~w[i];
         half();
         scl = 1'b1;
         half();
         res[i] = sda;
         scl = 1'b0;
      end
      got = 1'b1;
      @(posedge clk);
      #2;
      got = 1'b0;
   endtask
endmodule // dpe_master

// file: verif/dual_port_eeprom_read_wp_bench.sv
// Self-checking bench for the dual-port two-wire EEPROM block
`timescale 1ns/1ps
module dual_port_eeprom_read_wp_bench;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic vcp = 1'b0;
   logic vrun = 1'b1;
   logic vlvl = 1'b1;
   logic hp = 1'b0;
   logic sl = 1'b0;
   logic m_scl, m_low, m_got, h_scl, h_low, h_got, m_oe, h_oe, tx_only, m_out, h_out;
   logic [8:0] m_res, h_res, a;
   logic [8:0] q[$];
   logic [7:0] hmem [512];
   logic [7:0] mmem [128];
   logic [7:0] d;
   int bad_count = 0;
   int total_checks = 0;
   initial forever #12.5 core_clk = ~core_clk;
   initial forever #16 vcp = vrun ? ~vcp : vlvl;
   dpe_top #(.WRITE_CYCLES(400)) dpe_top_i (.core_clk(core_clk), .reset(reset),
      .video_clock_protect(vcp), .monitor_serial_clock(m_scl),
      .monitor_serial_data_in(~(m_low | m_oe)), .monitor_serial_data_out(m_out),
      .monitor_serial_data_oe(m_oe), .host_serial_clock(h_scl),
      .host_serial_data_in(~(h_low | h_oe)), .host_serial_data_out(h_out),
      .host_serial_data_oe(h_oe), .host_protect_pin(hp), .supply_low(sl),
      .monitor_transmit_only(tx_only));
   dpe_master mon_master (.clk(core_clk), .sda(~(m_low | m_oe)), .scl(m_scl),
      .sda_low(m_low), .got(m_got), .res(m_res));
   dpe_master host_master (.clk(core_clk), .sda(~(h_low | h_oe)), .scl(h_scl),
      .sda_low(h_low), .got(h_got), .res(h_res));
   // ==================================================================
   // Comparison and closing
   task automatic chk(input logic [8:0] r, input logic [8:0] e);
      total_checks++;
      if (r !== e) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, r, e);
      end
   endtask
   always @(posedge m_got or posedge h_got) chk(h_got ? h_res : m_res, q.pop_front());
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge core_clk);
      bad_count++;
      report_and_stop();
   end
   // ==================================================================
   // Bus tasks; p selects the host port
   task automatic st(input bit p);
      if (p) host_master.st();
      else mon_master.st();
   endtask
   task automatic sp(input bit p);
      if (p) host_master.sp();
      else mon_master.sp();
   endtask
   task automatic bx(input bit p, input logic [7:0] b, input logic k, input logic [8:0] e);
      q.push_back(e);
      if (p) host_master.xfer(b, k);
      else mon_master.xfer(b, k);
   endtask
   function automatic logic [7:0] cb(input bit p, input logic [8:0] ad);
      logic [2:0] r;
      r = 3'($urandom);
      return {4'ha, r[2:1], p ? ad[8] : r[0], 1'b0};
   endfunction
   task automatic wr(input bit p, input logic [8:0] ad, input logic [7:0] v, input bit ok);
      logic [7:0] c;
      c = cb(p, ad);
      st(p);
      bx(p, c, 1'b1, {c, 1'b0});
      bx(p, ad[7:0], 1'b1, {ad[7:0], 1'b0});
      bx(p, v, 1'b1, {v, 1'b0});
      sp(p);
      if (ok && p) hmem[ad] = v;
      if (ok && !p) mmem[ad[6:0]] = v;
      // Poll at once: only a started write cycle refuses the control byte
      st(p);
      bx(p, c, 1'b1, {c, ok});
      sp(p);
      repeat (400) @(posedge core_clk);
      #2;
   endtask
   task automatic rd(input bit p, input logic [8:0] ad, input int n, input bit cur);
      logic [7:0] c;
      logic k;
      c = cb(p, ad);
      if (!cur) begin
         st(p);
         bx(p, c, 1'b1, {c, 1'b0});
         bx(p, ad[7:0], 1'b1, {ad[7:0], 1'b0});
      end
      st(p);
      c[0] = 1'b1;
      bx(p, c, 1'b1, {c, 1'b0});
      for (int i = 0; i < n; i++) begin
         k = (i == n - 1);
         bx(p, 8'hff, k, {p ? hmem[ad + 9'(i)] : mmem[7'(ad + 9'(i))], k});
      end
      sp(p);
   endtask
   // ==================================================================
   // Main sequence
   initial begin
      void'($urandom(32'h35b5));
      foreach (hmem[i]) hmem[i] = 8'hff;
      foreach (mmem[i]) mmem[i] = 8'hff;
      repeat (12) @(posedge core_clk);
      #2;
      reset = 1'b0;
      repeat (20) @(posedge core_clk);
      #2;
      a = 9'($urandom);
      d = 8'($urandom);
      wr(1'b1, a, d, 1'b1);
      rd(1'b1, a, 1, 1'b0);
      rd(1'b1, a + 9'h1, 2, 1'b1);
      wr(1'b1, 9'h1ff, ~d, 1'b1);
      rd(1'b1, 9'h1ff, 3, 1'b0);
      hp = 1'b1;
      wr(1'b1, a, ~d, 1'b0);
      hp = 1'b0;
      sl = 1'b1;
      wr(1'b1, a, ~d, 1'b0);
      sl = 1'b0;
      rd(1'b1, a, 1, 1'b0);
      st(1'b1);
      bx(1'b1, 8'h51, 1'b1, 9'h0a3);
      sp(1'b1);
      $display("test host port done");
      for (int i = 0; i < 100; i++) begin
         @(posedge core_clk);
         #2;
         chk({5'h0, m_out, h_out, tx_only, m_oe}, 9'h002);
      end
      $display("test stream done");
      vrun = 1'b0;
      st(1'b0);
      sp(1'b0);
      chk({8'h0, tx_only}, 9'h000);
      wr(1'b0, a, d, 1'b1);
      vlvl = 1'b0;
      wr(1'b0, a, ~d, 1'b0);
      rd(1'b0, a, 2, 1'b0);
      $display("test monitor port done");
      report_and_stop();
   end
endmodule // dual_port_eeprom_read_wp_bench
